// ==== verilog/cmosr_status_regs.sv ====
// Purpose: read-only status view of 32 message objects over AXI4-Lite
// Assumes: handler and message interface logic on the same clock
// Notes: flag registers ignore bus writes; event status is write-one-to-clear
//
// Overview of operation
// - tx pending reads one until sent
// - flag registers read only, writes ignored
// - objects 17-32 tx pending at 0x104
// - fresh data set by software or handler
// - cleared fresh data stays zero until rewritten
// - fresh data at 0x120 and 0x124
// - irq flag set by software or handler
// - irq flag change updates interrupt identifier
// - irq flag one marks interrupt source
// - objects 1-16 irq flags at 0x140
// - remote frame sets, sent clears tx pending
// - objects 1-16 tx pending at 0x100
// - objects 17-32 irq flags at 0x144
`timescale 1ns/1ns
module cmosr_status_regs #(
    parameter int NUM_OBJ = cmosr_pkg::NUM_OBJ
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    // message interface write into one object
    input wire logic IF_WRITE,
    input wire logic [4:0] IF_OBJ,
    input wire logic IF_TX_PENDING,
    input wire logic IF_FRESH_DATA,
    input wire logic IF_IRQ,
    // message handler events for one object
    input wire logic MH_REMOTE,
    input wire logic MH_RX_DATA,
    input wire logic MH_TX_DONE,
    input wire logic [4:0] MH_OBJ,
    input wire logic [NUM_OBJ-1:0] IRQ_ON_RX,
    input wire logic [NUM_OBJ-1:0] IRQ_ON_TX,
    // AXI4-Lite slave
    input wire logic [11:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [11:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // status outputs
    output logic [5:0] INTERRUPT_IDENTIFIER,
    output logic IRQ
);
    logic [NUM_OBJ-1:0] tx_pending;
    logic [NUM_OBJ-1:0] fresh_data;
    logic [NUM_OBJ-1:0] irq_flag;
    logic [NUM_OBJ-1:0] irq_flag_prev_reg;
    logic [2:0] evt_status_reg;
    logic [2:0] evt_mask_reg;
    logic [11:0] aw_addr_reg;
    logic aw_have_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_have_reg;
    logic [5:0] ident_next;

    // per-object flag cells
    genvar g;
    generate
        for (g = 0; g < NUM_OBJ; g++) begin : g_obj
            cmosr_flag_bit u_flag (
                .clk(CORE_CLK),
                .rst(RST),
                .sw_write(IF_WRITE && (IF_OBJ == 5'(g))),
                .sw_tx_pending(IF_TX_PENDING),
                .sw_fresh_data(IF_FRESH_DATA),
                .sw_irq(IF_IRQ),
                .ev_remote(MH_REMOTE && (MH_OBJ == 5'(g))),
                .ev_rx_data(MH_RX_DATA && (MH_OBJ == 5'(g))),
                .ev_tx_done(MH_TX_DONE && (MH_OBJ == 5'(g))),
                .irq_on_rx(IRQ_ON_RX[g]),
                .irq_on_tx(IRQ_ON_TX[g]),
                .tx_pending(tx_pending[g]),
                .fresh_data(fresh_data[g]),
                .irq_flag(irq_flag[g])
            );
        end
    endgenerate

    // lowest pending object wins the identifier, zero means none
    always_comb begin
        ident_next = cmosr_pkg::IDENT_RESET;
        for (int i = NUM_OBJ - 1; i >= 0; i--) begin
            if (irq_flag[i]) begin
                ident_next = 6'(i + 1);
            end
        end
    end

    // identifier follows every flag change one cycle later
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            INTERRUPT_IDENTIFIER <= cmosr_pkg::IDENT_RESET;
            irq_flag_prev_reg <= '0;
        end else begin
            irq_flag_prev_reg <= irq_flag;
            if (irq_flag != irq_flag_prev_reg || INTERRUPT_IDENTIFIER != ident_next) begin
                INTERRUPT_IDENTIFIER <= ident_next;
            end
        end
    end

    // register map lookup; upper half of flag words always zero
    function automatic logic [31:0] read_word(input logic [11:0] a);
        logic [31:0] w;
        w = 32'h00000000;
        unique case (a)
            cmosr_pkg::OFS_TX_PENDING_LOW: w[15:0] = tx_pending[15:0];
            cmosr_pkg::OFS_TX_PENDING_HIGH: w[15:0] = tx_pending[31:16];
            cmosr_pkg::OFS_FRESH_DATA_LOW: w[15:0] = fresh_data[15:0];
            cmosr_pkg::OFS_FRESH_DATA_HIGH: w[15:0] = fresh_data[31:16];
            cmosr_pkg::OFS_OBJ_IRQ_LOW: w[15:0] = irq_flag[15:0];
            cmosr_pkg::OFS_OBJ_IRQ_HIGH: w[15:0] = irq_flag[31:16];
            cmosr_pkg::OFS_EVT_STATUS: w[2:0] = evt_status_reg;
            cmosr_pkg::OFS_EVT_MASK: w[2:0] = evt_mask_reg;
            default: w = 32'h00000000;
        endcase
        return w;
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        return (a == cmosr_pkg::OFS_TX_PENDING_LOW) || (a == cmosr_pkg::OFS_TX_PENDING_HIGH)
            || (a == cmosr_pkg::OFS_FRESH_DATA_LOW) || (a == cmosr_pkg::OFS_FRESH_DATA_HIGH)
            || (a == cmosr_pkg::OFS_OBJ_IRQ_LOW) || (a == cmosr_pkg::OFS_OBJ_IRQ_HIGH)
            || (a == cmosr_pkg::OFS_EVT_STATUS) || (a == cmosr_pkg::OFS_EVT_MASK);
    endfunction

    wire wr_go = aw_have_reg && w_have_reg && !BVALID;
    wire wr_status = wr_go && (aw_addr_reg == cmosr_pkg::OFS_EVT_STATUS) && w_strb_reg[0];
    wire wr_mask = wr_go && (aw_addr_reg == cmosr_pkg::OFS_EVT_MASK) && w_strb_reg[0];

    // write address and data captured independently, in either order
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_addr_reg <= {AWADDR[11:2], 2'b00};
                aw_have_reg <= 1'b1;
                AWREADY <= 1'b0;
            end else if (wr_go) begin
                aw_have_reg <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_data_reg <= WDATA;
                w_strb_reg <= WSTRB;
                w_have_reg <= 1'b1;
                WREADY <= 1'b0;
            end else if (wr_go) begin
                w_have_reg <= 1'b0;
            end
            if (BVALID && BREADY) begin
                AWREADY <= 1'b1;
                WREADY <= 1'b1;
            end
        end
    end

    // write response; flag registers accept writes but never change
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            BVALID <= 1'b0;
            BRESP <= cmosr_pkg::RESP_OKAY;
        end else if (wr_go) begin
            BVALID <= 1'b1;
            BRESP <= is_mapped(aw_addr_reg) ? cmosr_pkg::RESP_OKAY : cmosr_pkg::RESP_SLVERR;
        end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // read channel; reading alters nothing
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= 32'h00000000;
            RRESP <= cmosr_pkg::RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RDATA <= read_word({ARADDR[11:2], 2'b00});
            RRESP <= is_mapped({ARADDR[11:2], 2'b00}) ? cmosr_pkg::RESP_OKAY
                                                       : cmosr_pkg::RESP_SLVERR;
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
        end
    end

    // event mask written by software
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            evt_mask_reg <= cmosr_pkg::EVT_RESET;
        end else if (wr_mask) begin
            evt_mask_reg <= w_data_reg[2:0];
        end
    end

    // sticky events; a new event beats a same-cycle clear
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            evt_status_reg <= cmosr_pkg::EVT_RESET;
        end else begin
            evt_status_reg <= (evt_status_reg & ~(wr_status ? w_data_reg[2:0] : 3'h0))
                | {MH_REMOTE, MH_RX_DATA, MH_TX_DONE};
        end
    end

    // registered level interrupt
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(evt_status_reg & evt_mask_reg);
        end
    end
endmodule // cmosr_status_regs

// ==== verilog/cmosr_pkg.sv ====
// Purpose: shared constants for the message object status register bank
// Assumes: 32 message objects, 16 flags per register word
// Notes: offsets are byte addresses on the register bus
package cmosr_pkg;
    localparam int NUM_OBJ = 32;
    localparam int FLAGS_PER_REG = 16;
    localparam logic [11:0] OFS_TX_PENDING_LOW = 12'h100;
    localparam logic [11:0] OFS_TX_PENDING_HIGH = 12'h104;
    localparam logic [11:0] OFS_FRESH_DATA_LOW = 12'h120;
    localparam logic [11:0] OFS_FRESH_DATA_HIGH = 12'h124;
    localparam logic [11:0] OFS_OBJ_IRQ_LOW = 12'h140;
    localparam logic [11:0] OFS_OBJ_IRQ_HIGH = 12'h144;
    localparam logic [11:0] OFS_EVT_STATUS = 12'h180;
    localparam logic [11:0] OFS_EVT_MASK = 12'h184;
    localparam logic [31:0] FLAG_RESET = 32'h00000000;
    localparam logic [2:0] EVT_RESET = 3'h0;
    localparam logic [5:0] IDENT_RESET = 6'h00;
    localparam int EVT_TX_DONE = 0;
    localparam int EVT_RX_DATA = 1;
    localparam int EVT_REMOTE = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== verilog/cmosr_flag_bit.sv ====
// Purpose: one message object's three status flags
// Assumes: handler events and interface writes are one-cycle pulses
// Notes: handler events take priority over software writes in the same cycle
`timescale 1ns/1ns
module cmosr_flag_bit (
    input wire logic clk,
    input wire logic rst,
    input wire logic sw_write,
    input wire logic sw_tx_pending,
    input wire logic sw_fresh_data,
    input wire logic sw_irq,
    input wire logic ev_remote,
    input wire logic ev_rx_data,
    input wire logic ev_tx_done,
    input wire logic irq_on_rx,
    input wire logic irq_on_tx,
    output logic tx_pending,
    output logic fresh_data,
    output logic irq_flag
);
    // transmit pending: remote frame sets, completed send clears
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_pending <= 1'b0;
        end else if (ev_remote) begin
            tx_pending <= 1'b1;
        end else if (ev_tx_done) begin
            tx_pending <= 1'b0;
        end else if (sw_write) begin
            tx_pending <= sw_tx_pending;
        end
    end

    // fresh data: set whenever the data portion is written, held until cleared
    always_ff @(posedge clk) begin
        if (rst) begin
            fresh_data <= 1'b0;
        end else if (ev_rx_data) begin
            fresh_data <= 1'b1;
        end else if (ev_tx_done) begin
            fresh_data <= 1'b0;
        end else if (sw_write) begin
            fresh_data <= sw_fresh_data;
        end
    end

    // interrupt pending: set by handler per object enables, software may clear
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_flag <= 1'b0;
        end else if ((ev_rx_data && irq_on_rx) || (ev_tx_done && irq_on_tx)) begin
            irq_flag <= 1'b1;
        end else if (sw_write) begin
            irq_flag <= sw_irq;
        end
    end
endmodule // cmosr_flag_bit

// ==== testbench/cmosr_status_regs_assertions.sv ====
// Purpose: port checks on the message object status bank
// Assumes: one clock, synchronous active-high reset
// Notes: flag contents are judged by the bench model
`timescale 1ns/1ns
module cmosr_chk #(
    parameter int NUM_OBJ = 32
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic MH_RX_DATA,
    input wire logic [4:0] MH_OBJ,
    input wire logic [NUM_OBJ-1:0] IRQ_ON_RX,
    input wire logic [5:0] INTERRUPT_IDENTIFIER,
    input wire logic IRQ
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // read answers are fixed at one cycle so software polling is cheap
    AST_RD_LAT: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
        else $error("read answer late");
    AST_RD_HI: assert property (RVALID |-> RDATA[31:16] == 16'h0)
        else $error("upper read bits set");
    AST_RD_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped");
    AST_WR_LAT: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write answer late");
    AST_WR_BUSY: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write taken while busy");
    // identifier follows a new source one edge after the flag
    AST_ID_RX: assert property (MH_RX_DATA && IRQ_ON_RX[MH_OBJ] |-> ##2
        (INTERRUPT_IDENTIFIER != 6'h00 &&
        INTERRUPT_IDENTIFIER <= {1'b0, $past(MH_OBJ, 2)} + 6'h01))
        else $error("identifier missed source");
    AST_ID_RANGE: assert property (INTERRUPT_IDENTIFIER <= 6'h20)
        else $error("identifier out of range");
    AST_RST_REL: assert property ($fell(RST) |-> !RVALID && !BVALID && ARREADY &&
        !IRQ && INTERRUPT_IDENTIFIER == 6'h00)
        else $error("not idle after reset");
endmodule // cmosr_chk
bind cmosr_status_regs cmosr_chk #(.NUM_OBJ(NUM_OBJ)) u_chk (.CORE_CLK(CORE_CLK), .RST(RST),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
    .BVALID(BVALID), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RVALID(RVALID), .RREADY(RREADY), .MH_RX_DATA(MH_RX_DATA), .MH_OBJ(MH_OBJ),
    .IRQ_ON_RX(IRQ_ON_RX), .INTERRUPT_IDENTIFIER(INTERRUPT_IDENTIFIER), .IRQ(IRQ));

// ==== testbench/can_msg_object_status_regs_tb.sv ====
// Purpose: random self-checking bench for the status bank
// Assumes: registered bus answers, flags change one edge after a pulse
// Notes: a bit-vector model is read back after every event
`timescale 1ns/1ns
module can_msg_object_status_regs_tb;
    logic CORE_CLK = 0, RST = 1, IF_WRITE = 0, IF_TX_PENDING = 0, IF_FRESH_DATA = 0;
    logic IF_IRQ = 0, MH_REMOTE = 0, MH_RX_DATA = 0, MH_TX_DONE = 0, AWVALID = 0;
    logic WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
    logic [4:0] IF_OBJ = 0, MH_OBJ = 0;
    logic [31:0] IRQ_ON_RX = 0, IRQ_ON_TX = 0, WDATA = 0, RDATA, m_tx, m_fd, m_ip;
    logic [31:0] rs = 32'he5cd;
    logic [11:0] AWADDR = 0, ARADDR = 0;
    logic [11:0] ofs [6] = '{12'h100, 12'h104, 12'h120, 12'h124, 12'h140, 12'h144};
    logic [1:0] BRESP, RRESP;
    logic [5:0] INTERRUPT_IDENTIFIER;
    logic [2:0] m_ev, m_mask;
    int err_total = 0, cmp_count = 0;
    always #50 CORE_CLK = ~CORE_CLK;
    cmosr_status_regs u_dut (.CORE_CLK(CORE_CLK), .RST(RST), .IF_WRITE(IF_WRITE),
        .IF_OBJ(IF_OBJ), .IF_TX_PENDING(IF_TX_PENDING), .IF_FRESH_DATA(IF_FRESH_DATA),
        .IF_IRQ(IF_IRQ), .MH_REMOTE(MH_REMOTE), .MH_RX_DATA(MH_RX_DATA),
        .MH_TX_DONE(MH_TX_DONE), .MH_OBJ(MH_OBJ), .IRQ_ON_RX(IRQ_ON_RX),
        .IRQ_ON_TX(IRQ_ON_TX), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .INTERRUPT_IDENTIFIER(INTERRUPT_IDENTIFIER), .IRQ(IRQ));
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask
    // each channel drops its valid only at the edge that takes it
    task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
        @(posedge CORE_CLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1;
        WVALID <= 1;
        BREADY <= 1;
        @(posedge CORE_CLK);
        while (AWVALID || WVALID || !BVALID) begin
            if (AWREADY) AWVALID <= 0;
            if (WREADY) WVALID <= 0;
            @(posedge CORE_CLK);
        end
        BREADY <= 0;
        chk("bresp", {30'h0, er}, {30'h0, BRESP});
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e, logic [1:0] er, string n);
        @(posedge CORE_CLK);
        ARADDR <= a;
        ARVALID <= 1;
        RREADY <= 1;
        @(posedge CORE_CLK);
        while (ARVALID || !RVALID) begin
            if (ARREADY) ARVALID <= 0;
            @(posedge CORE_CLK);
        end
        RREADY <= 0;
        chk(n, e, RDATA);
        chk("rresp", {30'h0, er}, {30'h0, RRESP});
    endtask
    function automatic logic [31:0] ex(int k);
        logic [31:0] v;
        v = k < 2 ? m_tx : (k < 4 ? m_fd : m_ip);
        return {16'h0, k[0] ? v[31:16] : v[15:0]};
    endfunction
    // one handler event or interface write, then the model follows
    task automatic ev(int op, logic [4:0] o, logic v);
        @(posedge CORE_CLK);
        MH_OBJ <= o;
        IF_OBJ <= o;
        {IF_TX_PENDING, IF_FRESH_DATA, IF_IRQ} <= {3{v}};
        {MH_REMOTE, MH_RX_DATA, MH_TX_DONE, IF_WRITE} <= 4'h8 >> op;
        @(posedge CORE_CLK);
        {MH_REMOTE, MH_RX_DATA, MH_TX_DONE, IF_WRITE} <= 4'h0;
        m_tx[o] = op == 0 ? 1'b1 : (op == 2 ? 1'b0 : (op == 3 ? v : m_tx[o]));
        m_fd[o] = op == 1 ? 1'b1 : (op == 2 ? 1'b0 : (op == 3 ? v : m_fd[o]));
        m_ip[o] = op == 3 ? v
            : m_ip[o] | (op == 1 && IRQ_ON_RX[o]) | (op == 2 && IRQ_ON_TX[o]);
        if (op < 3) m_ev[2 - op] = 1'b1;
    endtask
    task automatic check_all();
        logic [5:0] id;
        id = 6'h00;
        for (int k = 0; k < 6; k++) rd(ofs[k], ex(k), 2'h0, "flag_reg");
        for (int i = 31; i >= 0; i--) if (m_ip[i]) id = 6'(i + 1);
        rd(12'h180, {29'h0, m_ev}, 2'h0, "evt_status");
        rd(12'h184, {29'h0, m_mask}, 2'h0, "evt_mask");
        chk("ident", {26'h0, id}, {26'h0, INTERRUPT_IDENTIFIER});
        chk("irq", {31'h0, |(m_ev & m_mask)}, {31'h0, IRQ});
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        logic [31:0] d;
        repeat (5) @(posedge CORE_CLK);
        RST <= 0;
        {m_tx, m_fd, m_ip, m_ev, m_mask} = '0;
        check_all();
        rd(12'h1f0, 32'h0, 2'h2, "unmapped");
        wr(12'h1f0, rnd(), 2'h2);
        for (int i = 0; i < 80; i++) begin
            IRQ_ON_RX <= rnd();
            IRQ_ON_TX <= rnd();
            ev(int'(rnd() % 4), 5'(rnd()), 1'(rnd()));
            d = rnd();
            wr(12'h184, d, 2'h0);
            m_mask = d[2:0];
            d = rnd();
            wr(12'h180, d, 2'h0);
            m_ev = m_ev & ~d[2:0];
            d = rnd();
            wr(ofs[d[31:29] % 3'h6], d, 2'h0);
            check_all();
        end
        complete_run();
    end
    // hang guard sized well past the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        err_total++;
        complete_run();
    end
endmodule // can_msg_object_status_regs_tb
